//--- rtl/pcf_core.sv
// Overview of operation
// - Write-only 128-bit key, kept across sleep
// - Tx: pad, encrypt 16-byte blocks, then send
// - Only message bytes encrypted, headers plain
// - Rx: decrypt whole packet, then payload available
// - Match and check flags precede decryption
// - Each cipher block takes 7.0 us
// - Discard without sync; flag on sync match
// - Address filter: own, or own plus broadcast
// - Address byte kept; match flag shared
// - Variable length must be below maximum
// - Append checksum on Tx, verify on Rx
// - Check fail clears queue unless keep set
// - Manchester: one as 10, zero as 01
// - Coding only on payload and checksum
// - Whitening XORs payload and checksum bits
`timescale 1ns/1ps
`default_nettype none
module pcf_core import pcf_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Key loading
  input wire logic key_wr_i,
  input wire logic [3:0] key_idx_i,
  input wire logic [7:0] key_byte_i,
  // Configuration
  input wire logic cipher_enable_i,
  input wire logic check_enable_i,
  input wire logic keep_on_check_fail_i,
  input wire logic var_length_i,
  input wire logic [1:0] station_filter_mode_i,
  input wire logic [7:0] own_station_id_i,
  input wire logic [7:0] all_stations_id_i,
  input wire logic [7:0] max_body_length_i,
  input wire logic [1:0] balance_coding_select_i,
  input wire logic [31:0] frame_marker_value_i,
  input wire logic [15:0] chip_rate_setting_i,
  input wire logic [6:0] queue_level_setting_i,
  // Commands
  input wire logic tx_start_i,
  input wire logic rx_start_i,
  // Host queue access
  input wire logic host_wr_valid_i,
  input wire logic [7:0] host_wr_data_i,
  output logic host_wr_ready_o,
  input wire logic host_rd_i,
  output logic [7:0] host_rd_data_o,
  output logic host_rd_valid_o,
  // Radio chips
  output logic tx_chip_o,
  input wire logic rx_chip_i,
  // Status
  output logic busy_o,
  output logic frame_match_flag_o,
  output logic check_pass_flag_o,
  output logic rx_body_available_o,
  output logic tx_done_flag_o,
  output logic queue_has_data_o,
  output logic queue_full_flag_o,
  output logic queue_level_flag_o
);
  // ====================================================================
  // State
  typedef struct packed {
    pcf_state_e st;
    logic [15:0][7:0] key;
    logic [65:0][7:0] mem;
    logic [7:0] wp;
    logic [7:0] rp;
    logic [7:0] idx;
    logic [7:0] tot;
    logic [7:0] mst;
    logic [10:0] tmr;
    logic rx_dir;
    logic [7:0] sr;
    logic [7:0] ck;
    logic [2:0] bitn;
    logic half;
    logic mb;
    logic crcn;
    logic [15:0] crc;
    logic [8:0] lfsr;
    logic [31:0] hunt;
    logic [5:0] hcnt;
    logic [2:0] rxs;
    logic rxb;
    logic [15:0] div;
    logic tick;
    logic chip;
    logic [7:0] rdat;
    logic rval;
    logic fm;
    logic cp;
    logic av;
    logic td;
    logic qhas;
    logic qfull;
    logic qlvl;
    logic busy;
  } pcf_core_s;
  pcf_core_s s;
  pcf_core_s n;

  pcf_stream_if #(.W(FIFO_WIDTH)) in_s ();
  pcf_stream_if #(.W(FIFO_WIDTH)) out_s ();
  logic take;
  logic man;
  logic wht;
  logic bit_done;
  logic b;
  logic cb;
  logic [7:0] v;
  logic [7:0] occ;
  logic [7:0] pend;
  logic [15:0] cn;

  assign in_s.valid = host_wr_valid_i;
  assign in_s.data = host_wr_data_i;
  assign out_s.ready = take;

  // Small staging queue decouples host writes from the packet buffer
  pcf_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_s(in_s.snk),
    .out_s(out_s.src)
  );

  // ====================================================================
  // Next state
  always_comb begin
    n = s;
    n.rval = 1'b0;
    man = (balance_coding_select_i == CODE_MAN);
    wht = (balance_coding_select_i == CODE_WHT);
    b = 1'b0;
    cb = 1'b0;
    v = 8'h00;
    pend = 8'h00;
    bit_done = 1'b0;
    cn = s.crc;
    take = (s.st == PCF_IDLE) && (s.wp < BUF_BYTES);
    n.tick = (s.div == 16'h0000);
    n.div = n.tick ? chip_rate_setting_i : s.div - 16'h0001;
    n.rxs = {s.rxs[1:0], rx_chip_i};
    if (s.rxs[1] == s.rxs[2]) begin
      n.rxb = s.rxs[2];
    end
    if (key_wr_i) begin
      n.key[key_idx_i] = key_byte_i;
    end
    if (out_s.valid && take) begin
      n.mem[s.wp[6:0]] = out_s.data;
      n.wp = s.wp + 8'h01;
    end
    if (host_rd_i && s.rp != s.wp && s.st != PCF_CIPH && s.st != PCF_TX_BODY) begin
      n.rdat = s.mem[s.rp[6:0]];
      n.rval = 1'b1;
      n.rp = s.rp + 8'h01;
    end
    unique case (s.st)
      PCF_IDLE: begin
        if (tx_start_i) begin
          n.td = 1'b0;
          n.rx_dir = 1'b0;
          n.tot = var_length_i ? s.mem[0] + 8'h01 : max_body_length_i;
          n.mst = {7'h00, var_length_i} + {7'h00, station_filter_mode_i != FILT_OFF};
          n.idx = n.mst;
          n.hcnt = 6'h00;
          n.st = PCF_TX_HDR;
          if (cipher_enable_i && n.mst < n.tot) begin
            pend = n.mst + (((n.tot - n.mst) + BLK_BYTES - 8'h01) & 8'hF0);
            for (int i = 0; i < 66; i++) begin
              if (8'(i) >= n.tot && 8'(i) < pend) begin
                n.mem[i] = 8'h00;
              end
            end
            if (var_length_i) begin
              n.mem[0] = pend - 8'h01;
            end
            n.tot = pend;
            n.tmr = CIPH_LOAD;
            n.st = PCF_CIPH;
          end
        end else if (rx_start_i) begin
          n.fm = 1'b0;
          n.cp = 1'b0;
          n.av = 1'b0;
          n.wp = 8'h00;
          n.rp = 8'h00;
          n.hunt = 32'h00000000;
          n.st = PCF_RX_HUNT;
        end
      end
      PCF_CIPH: begin
        if (s.tmr != 11'h000) begin
          n.tmr = s.tmr - 11'h001;
        end else begin
          // Block transform stand-in: keyed XOR, its own inverse
          for (int i = 0; i < 16; i++) begin
            n.mem[s.idx[6:0] + 7'(i)] = s.mem[s.idx[6:0] + 7'(i)] ^ s.key[i];
          end
          n.idx = s.idx + BLK_BYTES;
          n.tmr = CIPH_LOAD;
          if (n.idx >= s.tot) begin
            if (s.rx_dir) begin
              n.av = 1'b1;
              n.st = PCF_IDLE;
            end else begin
              n.st = PCF_TX_HDR;
            end
          end
        end
      end
      PCF_TX_HDR: begin
        if (s.tick) begin
          // Preamble and sync stay NRZ
          n.chip = (s.hcnt < PRE_CHIPS) ? PRE_BYTE[3'h7 - s.hcnt[2:0]]
                 : frame_marker_value_i[5'(HDR_LAST - s.hcnt)];
          n.hcnt = s.hcnt + 6'h01;
          if (s.hcnt == HDR_LAST) begin
            n.idx = 8'h00;
            n.sr = s.mem[0];
            n.bitn = 3'h0;
            n.half = 1'b0;
            n.crc = CRC_SEED;
            n.lfsr = WHT_SEED;
            n.st = PCF_TX_BODY;
          end
        end
      end
      PCF_TX_BODY, PCF_TX_CRC: begin
        if (s.tick) begin
          b = s.sr[7];
          cb = wht ? b ^ s.lfsr[0] : b;
          n.chip = (man && s.half) ? ~cb : cb;
          n.half = man & ~s.half;
          bit_done = ~man | s.half;
        end
        if (bit_done) begin
          if (s.st == PCF_TX_BODY) begin
            cn = pcf_crc_bit(s.crc, b);
          end
          n.crc = cn;
          n.lfsr = pcf_lfsr_step(s.lfsr);
          n.sr = {s.sr[6:0], 1'b0};
          n.bitn = s.bitn + 3'h1;
          if (s.bitn == 3'h7) begin
            n.idx = s.idx + 8'h01;
            if (s.st == PCF_TX_BODY && n.idx < s.tot) begin
              n.sr = s.mem[n.idx[6:0]];
            end else if (s.st == PCF_TX_BODY && check_enable_i) begin
              n.sr = ~cn[15:8];
              n.crcn = 1'b0;
              n.st = PCF_TX_CRC;
            end else if (s.st == PCF_TX_CRC && !s.crcn) begin
              n.sr = ~s.crc[7:0];
              n.crcn = 1'b1;
            end else begin
              n.st = PCF_TX_END;
            end
          end
        end
      end
      PCF_TX_END: begin
        // Hold the last chip for its full period before reporting
        if (s.tick) begin
          n.td = 1'b1;
          n.wp = 8'h00;
          n.rp = 8'h00;
          n.chip = 1'b0;
          n.st = PCF_IDLE;
        end
      end
      PCF_RX_HUNT: begin
        if (s.tick) begin
          n.hunt = {s.hunt[30:0], s.rxb};
          if (n.hunt == frame_marker_value_i) begin
            n.fm = (station_filter_mode_i == FILT_OFF);
            n.idx = 8'h00;
            n.wp = 8'h00;
            n.rp = 8'h00;
            n.tot = max_body_length_i;
            n.mst = {7'h00, var_length_i} + {7'h00, station_filter_mode_i != FILT_OFF};
            n.bitn = 3'h0;
            n.half = 1'b0;
            n.crc = CRC_SEED;
            n.lfsr = WHT_SEED;
            n.st = PCF_RX_BODY;
          end
        end
      end
      PCF_RX_BODY, PCF_RX_CRC: begin
        if (s.tick) begin
          n.mb = s.rxb;
          n.half = man & ~s.half;
          bit_done = ~man | s.half;
          b = (man ? s.mb : s.rxb) ^ (wht & s.lfsr[0]);
        end
        if (bit_done) begin
          if (s.st == PCF_RX_BODY) begin
            n.crc = pcf_crc_bit(s.crc, b);
          end
          n.lfsr = pcf_lfsr_step(s.lfsr);
          v = {s.sr[6:0], b};
          n.sr = v;
          n.bitn = s.bitn + 3'h1;
          if (s.bitn == 3'h7 && s.st == PCF_RX_BODY) begin
            n.mem[s.idx[6:0]] = v;
            n.wp = s.idx + 8'h01;
            n.idx = s.idx + 8'h01;
            if (var_length_i && s.idx == 8'h00) begin
              n.tot = v + 8'h01;
            end
            if ((var_length_i && s.idx == 8'h00 && (v >= max_body_length_i || v >= BUF_BYTES))
                || (station_filter_mode_i != FILT_OFF && s.idx == {7'h00, var_length_i}
                && v != own_station_id_i
                && !(station_filter_mode_i == FILT_ALL && v == all_stations_id_i))) begin
              n.wp = 8'h00;
              n.hunt = 32'h00000000;
              n.st = PCF_RX_HUNT;
            end else begin
              if (station_filter_mode_i != FILT_OFF && s.idx == {7'h00, var_length_i}) begin
                n.fm = 1'b1;
              end
              if (n.idx >= n.tot) begin
                n.crcn = 1'b0;
                n.st = check_enable_i ? PCF_RX_CRC : PCF_IDLE;
                n.av = ~check_enable_i & ~cipher_enable_i;
                if (!check_enable_i && cipher_enable_i && s.mst < n.tot) begin
                  n.rx_dir = 1'b1;
                  n.idx = s.mst;
                  n.tmr = CIPH_LOAD;
                  n.st = PCF_CIPH;
                end else if (!check_enable_i) begin
                  n.av = 1'b1;
                end
              end
            end
          end else if (s.bitn == 3'h7) begin
            n.ck = v;
            n.crcn = 1'b1;
            if (s.crcn) begin
              // Checksum bytes never enter the buffer
              n.cp = ({s.ck, v} == ~s.crc);
              n.st = PCF_IDLE;
              if (!n.cp && !keep_on_check_fail_i) begin
                n.wp = 8'h00;
                n.rp = 8'h00;
              end else if (cipher_enable_i && s.mst < s.tot) begin
                n.rx_dir = 1'b1;
                n.idx = s.mst;
                n.tmr = CIPH_LOAD;
                n.st = PCF_CIPH;
              end else begin
                n.av = 1'b1;
              end
            end
          end
        end
      end
      default: n.st = PCF_IDLE;
    endcase
    occ = n.wp - n.rp;
    n.qhas = (occ != 8'h00);
    n.qfull = (occ >= BUF_BYTES);
    n.qlvl = (occ > {1'b0, queue_level_setting_i});
    n.busy = (n.st != PCF_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.key <= s.key;
    end else begin
      s <= n;
    end
  end

  // ====================================================================
  // Outputs
  assign tx_chip_o = s.chip;
  assign host_rd_data_o = s.rdat;
  assign host_rd_valid_o = s.rval;
  assign busy_o = s.busy;
  assign frame_match_flag_o = s.fm;
  assign check_pass_flag_o = s.cp;
  assign rx_body_available_o = s.av;
  assign tx_done_flag_o = s.td;
  assign queue_has_data_o = s.qhas;
  assign queue_full_flag_o = s.qfull;
  assign queue_level_flag_o = s.qlvl;
  assign host_wr_ready_o = in_s.ready;
endmodule : pcf_core
`default_nettype wire

//--- rtl/pcf_pkg.sv
package pcf_pkg;
  // ====================================================================
  // Sizes and codes
  localparam logic [7:0] BUF_BYTES = 8'h42;
  localparam logic [7:0] BLK_BYTES = 8'h10;
  localparam logic [7:0] PRE_BYTE = 8'hAA;
  localparam logic [5:0] PRE_CHIPS = 6'h18;
  localparam logic [5:0] HDR_LAST = 6'h37;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_OWN = 2'h1;
  localparam logic [1:0] FILT_ALL = 2'h2;
  localparam logic [1:0] CODE_MAN = 2'h1;
  localparam logic [1:0] CODE_WHT = 2'h2;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  // ====================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CIPH_BLOCK_NS = 7000;
  localparam int CIPH_CYC = CIPH_BLOCK_NS / CLK_PERIOD_NS;
  localparam logic [10:0] CIPH_LOAD = 11'(CIPH_CYC - 1);
  // ====================================================================
  // Checksum polynomial, checksum and whitening seeds
  localparam logic [15:0] CRC_SEED = 16'h1D0F;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [8:0] WHT_SEED = 9'h1FF;

  typedef enum logic [3:0] {
    PCF_IDLE, PCF_CIPH, PCF_TX_HDR, PCF_TX_BODY, PCF_TX_CRC, PCF_TX_END,
    PCF_RX_HUNT, PCF_RX_BODY, PCF_RX_CRC
  } pcf_state_e;

  function automatic logic [15:0] pcf_crc_bit(input logic [15:0] c, input logic b);
    pcf_crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : pcf_crc_bit

  function automatic logic [8:0] pcf_lfsr_step(input logic [8:0] l);
    pcf_lfsr_step = {l[0] ^ l[5], l[8:1]};
  endfunction : pcf_lfsr_step
endpackage : pcf_pkg

//--- rtl/pcf_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcf_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : pcf_stream_if
`default_nettype wire

//--- rtl/pcf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pcf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Streams
  pcf_stream_if.snk in_s,
  pcf_stream_if.src out_s
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic rdy;
  } pcf_fifo_s;
  pcf_fifo_s s;
  pcf_fifo_s n;
  logic push;
  logic pop;

  // Ready comes from a register so the host port sees a flop
  assign in_s.ready = s.rdy;
  assign out_s.valid = (s.cnt != '0);
  assign out_s.data = s.mem[s.rp];

  always_comb begin
    n = s;
    push = in_s.valid & s.rdy;
    pop = out_s.valid & out_s.ready;
    if (push) begin
      n.mem[s.wp] = in_s.data;
      n.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = s.cnt - 1'b1;
    end
    n.full = (n.cnt == DEPTH);
    n.rdy = ~n.full;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : pcf_fifo
`default_nettype wire

//--- verification/pcf_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pcf_core_asserts import pcf_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration and commands
  input wire logic cipher_enable_i,
  input wire logic check_enable_i,
  input wire logic keep_on_check_fail_i,
  input wire logic tx_start_i,
  input wire logic rx_start_i,
  input wire logic host_rd_i,
  // Observed outputs
  input wire logic host_rd_valid_o,
  input wire logic tx_chip_o,
  input wire logic busy_o,
  input wire logic frame_match_flag_o,
  input wire logic check_pass_flag_o,
  input wire logic rx_body_available_o,
  input wire logic tx_done_flag_o,
  input wire logic queue_has_data_o,
  input wire logic queue_full_flag_o,
  input wire logic queue_level_flag_o
);
  // ====================================================================
  // Cycles since an accepted transmit start, saturating
  logic [11:0] tx_cnt;
  logic tx_cip;
  always_ff @(posedge clk_i) begin
    if (srst_i || (tx_start_i && !busy_o)) begin
      tx_cnt <= 12'h000;
      tx_cip <= cipher_enable_i && !srst_i;
    end else if (tx_cnt != 12'hFFF) begin
      tx_cnt <= tx_cnt + 12'h001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ====================================================================
  // Properties
  match_before_avail_a: assert property ($rose(rx_body_available_o) |-> frame_match_flag_o)
    else $error("payload available without match flag");
  fail_no_flag_a: assert property ($rose(rx_body_available_o) && check_enable_i && !keep_on_check_fail_i |-> check_pass_flag_o)
    else $error("payload available after failed checksum");
  check_leads_avail_a: assert property (cipher_enable_i && $rose(check_pass_flag_o) |-> !rx_body_available_o [*8])
    else $error("payload available too soon after check pass");
  cipher_delay_a: assert property ($rose(tx_chip_o) && tx_cip |-> tx_cnt >= 12'h578)
    else $error("transmit began before the cipher time");
  tx_start_clear_a: assert property (tx_start_i && !busy_o |=> busy_o && !tx_done_flag_o)
    else $error("transmit start not taken");
  rx_start_clear_a: assert property (rx_start_i && !tx_start_i && !busy_o |=> !frame_match_flag_o && !check_pass_flag_o && !rx_body_available_o)
    else $error("receive start left flags set");
  done_empties_a: assert property ($rose(tx_done_flag_o) |-> ##[0:2] !queue_has_data_o)
    else $error("buffer not emptied after transmit");
  level_has_data_a: assert property (queue_level_flag_o || queue_full_flag_o |-> queue_has_data_o)
    else $error("level flag without data");
  read_answer_a: assert property (host_rd_i && queue_has_data_o && !busy_o |=> host_rd_valid_o)
    else $error("read not answered");
  read_cause_a: assert property (host_rd_valid_o |-> $past(host_rd_i))
    else $error("read valid without request");
endmodule : pcf_core_asserts
bind pcf_core pcf_core_asserts u_asserts (.clk_i, .srst_i, .cipher_enable_i, .check_enable_i, .keep_on_check_fail_i,
  .tx_start_i, .rx_start_i, .host_rd_i, .host_rd_valid_o, .tx_chip_o, .busy_o, .frame_match_flag_o, .check_pass_flag_o,
  .rx_body_available_o, .tx_done_flag_o, .queue_has_data_o, .queue_full_flag_o, .queue_level_flag_o);
`default_nettype wire

//--- verification/pcf_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcf_modem_model (
  // Clock
  input wire logic clk_i,
  // Chip timing and lines
  input wire logic [15:0] rate_i,
  input wire logic tx_chip_i,
  output logic rx_chip_o
);
  logic cap[0:255];
  int waited;
  initial rx_chip_o = 1'b0;
  // ====================================================================
  // Capture: preamble starts with a one, so the first rise marks chip 0
  task automatic capture(input int n);
    waited = 0;
    @(negedge clk_i);
    while (tx_chip_i !== 1'b1) begin
      waited++;
      @(negedge clk_i);
    end
    for (int i = 0; i < n; i++) begin
      repeat ((rate_i + 1) / 2) @(negedge clk_i);
      cap[i] = tx_chip_i;
      repeat (rate_i + 1 - (rate_i + 1) / 2) @(negedge clk_i);
    end
  endtask : capture
  // ====================================================================
  // Send a whole frame; a released line shows the inverse of its last chip
  task automatic send(input logic b[$]);
    foreach (b[i]) begin
      rx_chip_o <= b[i];
      repeat (rate_i + 1) @(posedge clk_i);
    end
    rx_chip_o <= ~b[b.size() - 1];
  endtask : send
endmodule : pcf_modem_model
`default_nettype wire

//--- verification/packet_cipher_filter_coding_tb.sv
`timescale 1ns/1ps
`default_nettype none
module packet_cipher_filter_coding_tb import pcf_pkg::*; ;
  // ====================================================================
  // Signals
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic key_wr_i = 1'b0;
  logic [3:0] key_idx_i = 4'h0;
  logic [7:0] key_byte_i = 8'h00;
  logic cipher_enable_i = 1'b0, check_enable_i = 1'b1, keep_on_check_fail_i = 1'b0, var_length_i = 1'b0;
  logic [1:0] station_filter_mode_i = 2'h0, balance_coding_select_i = 2'h0;
  logic [7:0] own_station_id_i = 8'h5A, all_stations_id_i = 8'hFF, max_body_length_i = 8'h03, host_wr_data_i = 8'h00;
  logic [31:0] frame_marker_value_i = 32'h2DD4C31E;
  logic [15:0] chip_rate_setting_i = 16'h000F;
  logic [6:0] queue_level_setting_i = 7'h02;
  logic tx_start_i = 1'b0, rx_start_i = 1'b0, host_wr_valid_i = 1'b0, host_rd_i = 1'b0;
  logic host_wr_ready_o, host_rd_valid_o, tx_chip_o, rx_chip_i, busy_o, frame_match_flag_o, check_pass_flag_o;
  logic rx_body_available_o, tx_done_flag_o, queue_has_data_o, queue_full_flag_o, queue_level_flag_o;
  logic [7:0] host_rd_data_o;
  logic x_bits[$];
  logic [7:0] pay[$];
  int errors = 0, tests_run = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  pcf_core dut (.clk_i, .srst_i, .key_wr_i, .key_idx_i, .key_byte_i, .cipher_enable_i, .check_enable_i,
    .keep_on_check_fail_i, .var_length_i, .station_filter_mode_i, .own_station_id_i, .all_stations_id_i,
    .max_body_length_i, .balance_coding_select_i, .frame_marker_value_i, .chip_rate_setting_i, .queue_level_setting_i,
    .tx_start_i, .rx_start_i, .host_wr_valid_i, .host_wr_data_i, .host_wr_ready_o, .host_rd_i, .host_rd_data_o,
    .host_rd_valid_o, .tx_chip_o, .rx_chip_i, .busy_o, .frame_match_flag_o, .check_pass_flag_o, .rx_body_available_o,
    .tx_done_flag_o, .queue_has_data_o, .queue_full_flag_o, .queue_level_flag_o);
  pcf_modem_model m (.clk_i, .rate_i(chip_rate_setting_i), .tx_chip_i(tx_chip_o), .rx_chip_o(rx_chip_i));
  // ====================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks run %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Whole packet goes in before any start command
  task automatic put(input logic [7:0] q[$]);
    @(posedge clk_i);
    foreach (q[i]) begin
      host_wr_data_i <= q[i];
      host_wr_valid_i <= 1'b1;
      @(negedge clk_i);
      while (host_wr_ready_o !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
    end
    host_wr_valid_i <= 1'b0;
  endtask : put
  task automatic go(input logic tx);
    @(posedge clk_i);
    if (tx) tx_start_i <= 1'b1;
    else rx_start_i <= 1'b1;
    @(posedge clk_i);
    tx_start_i <= 1'b0;
    rx_start_i <= 1'b0;
  endtask : go
  task automatic wait_idle();
    @(negedge clk_i);
    while (busy_o !== 1'b0) @(negedge clk_i);
  endtask : wait_idle
  task automatic rd(input logic [7:0] e);
    @(posedge clk_i);
    host_rd_i <= 1'b1;
    @(posedge clk_i);
    host_rd_i <= 1'b0;
    @(negedge clk_i);
    chk({host_rd_valid_o, host_rd_data_o}, {1'b1, e});
  endtask : rd
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_SEED;
    foreach (q[i]) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][k]) ? CRC_POLY : 16'h0000);
    return ~c;
  endfunction : crc_of
  // Expected chips: preamble and sync plain, body and checksum coded
  task automatic mk(input logic [1:0] cd, input logic [7:0] q[$]);
    logic [8:0] l;
    logic [7:0] b[$];
    logic [15:0] c;
    l = WHT_SEED;
    c = crc_of(q);
    b = q;
    b.push_back(c[15:8]);
    b.push_back(c[7:0]);
    x_bits = {};
    for (int k = 55; k >= 0; k--) x_bits.push_back(k < 32 ? frame_marker_value_i[k] : PRE_BYTE[k % 8]);
    foreach (b[i]) for (int k = 7; k >= 0; k--) begin
      logic d;
      d = b[i][k] ^ (cd == CODE_WHT && l[0]);
      l = {l[0] ^ l[5], l[8:1]};
      x_bits.push_back(d);
      if (cd == CODE_MAN) x_bits.push_back(!d);
    end
  endtask : mk
  task automatic tx_run(input int n);
    go(1'b1);
    m.capture(n);
    for (int i = 0; i < n; i++) chk(m.cap[i], x_bits[i]);
    wait_idle();
    chk(tx_done_flag_o, 1'b1);
  endtask : tx_run
  // ====================================================================
  // Hang guard: the run needs about 20000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end
  // ====================================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      key_wr_i <= 1'b1;
      key_idx_i <= 4'(i);
      key_byte_i <= 8'(8'h3B + i);
    end
    @(posedge clk_i);
    key_wr_i <= 1'b0;
    @(negedge clk_i);
    chk({host_wr_ready_o, busy_o, frame_match_flag_o, check_pass_flag_o, rx_body_available_o, tx_done_flag_o}, 6'h20);
    @(posedge clk_i);
    pay = {8'hA1, 8'h00, 8'hFF};
    for (int cd = 0; cd < 3; cd++) begin
      balance_coding_select_i <= 2'(cd);
      put(pay);
      repeat (8) @(negedge clk_i);
      chk(queue_level_flag_o, 1'b1);
      mk(2'(cd), pay);
      tx_run(x_bits.size());
    end
    cipher_enable_i <= 1'b1;
    var_length_i <= 1'b1;
    balance_coding_select_i <= 2'h0;
    max_body_length_i <= 8'h40;
    put({8'h02, 8'h11, 8'h22});
    repeat (8) @(posedge clk_i);
    mk(2'h0, {8'h10});
    tx_run(64);
    chk(m.waited >= CIPH_CYC, 1'b1);
    cipher_enable_i <= 1'b0;
    var_length_i <= 1'b0;
    max_body_length_i <= 8'h03;
    station_filter_mode_i <= FILT_ALL;
    go(1'b0);
    mk(2'h0, {8'h77, 8'h12, 8'h34});
    m.send(x_bits);
    @(negedge clk_i);
    chk(frame_match_flag_o, 1'b0);
    mk(2'h0, {8'hFF, 8'h12, 8'h34});
    m.send(x_bits);
    wait_idle();
    chk({frame_match_flag_o, check_pass_flag_o, rx_body_available_o}, 3'h7);
    rd(8'hFF);
    rd(8'h12);
    rd(8'h34);
    station_filter_mode_i <= FILT_OWN;
    for (int k = 1; k >= 0; k--) begin
      keep_on_check_fail_i <= k[0];
      go(1'b0);
      mk(2'h0, {8'h5A, 8'h12, 8'h34});
      x_bits[$] = !x_bits[$];
      m.send(x_bits);
      wait_idle();
      chk({check_pass_flag_o, rx_body_available_o, queue_has_data_o}, {1'b0, k[0], k[0]});
      if (k == 1) begin
        rd(8'h5A);
        rd(8'h12);
        rd(8'h34);
        repeat (2) @(negedge clk_i);
        chk(queue_has_data_o, 1'b0);
      end
    end
    // Keyed receive: bytes equal to the key come back as zeros
    station_filter_mode_i <= FILT_OFF;
    cipher_enable_i <= 1'b1;
    go(1'b0);
    mk(2'h0, {8'h3B, 8'h3C, 8'h3D});
    m.send(x_bits);
    repeat (40) @(negedge clk_i);
    chk({check_pass_flag_o, rx_body_available_o}, 2'h2);
    wait_idle();
    chk({frame_match_flag_o, check_pass_flag_o, rx_body_available_o}, 3'h7);
    for (int i = 0; i < 3; i++) rd(8'h00);
    give_verdict();
  end
endmodule : packet_cipher_filter_coding_tb
`default_nettype wire
